// [design/ram_pkg.sv]
// Shared constants, shapes and helpers for the embedded RAM block
package ram_pkg;

  // Storage size and port widths
  localparam int MEM_BITS = 4096;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 11;
  localparam int BASE_W = 12;

  // Memory shapes, words by bits
  typedef enum logic [1:0] {
    SHAPE_256X16,
    SHAPE_512X8,
    SHAPE_1024X4,
    SHAPE_2048X2
  } shape_t;

  // Bit positions in the register/bypass select word
  localparam int SEL_DIN = 0;
  localparam int SEL_DOUT = 1;
  localparam int SEL_WADDR = 2;
  localparam int SEL_WE = 3;
  localparam int SEL_RADDR = 4;
  localparam int SEL_RE = 5;
  localparam int SEL_W = 6;

  // Clock source select codes
  localparam logic [1:0] CLK_FROM_PIN = 2'h0;
  localparam logic [1:0] CLK_FROM_GLOBAL = 2'h1;
  localparam logic [1:0] CLK_FROM_LOCAL = 2'h2;

  // Values after reset
  localparam logic [2:0] SYNC_RST = 3'h0;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [10:0] ADDR_RST = 11'h000;

  // Lane mask of valid data bits for a shape
  function automatic logic [15:0] data_mask(input logic [1:0] shape);
    data_mask = 16'hFFFF >> (16 - (16 >> shape));
  endfunction

endpackage

// [design/ram_core_if.sv]
// Connection between the block control logic and its storage array
`timescale 1ns/100ps
interface ram_core_if;
  logic we;
  logic [11:0] wbase;
  logic [15:0] wdata;
  logic [11:0] rbase;
  logic [1:0] shape;
  logic [15:0] rdata;

  modport ctrl (output we, output wbase, output wdata, output rbase, output shape, input rdata);
  modport store (input we, input wbase, input wdata, input rbase, input shape, output rdata);
endinterface

// [design/ram_core.sv]
// Storage array of 4096 bits addressed at a bit base with shape-wide lanes
`timescale 1ns/100ps
module ram_core #(
  parameter logic [4095:0] PRELOAD = '0 // Contents loaded at configuration
) (
  input wire logic ref_clk, // System clock
  input wire logic reset, // Configuration reset, loads preload image
  ram_core_if.store bus // Port from the control logic
);

  typedef struct packed {
    logic [ram_pkg::MEM_BITS-1:0] mem;
  } core_st_t;

  core_st_t st_r;
  core_st_t st_nxt;
  logic [15:0] mask;

  // Lane write and shaped read
  always_comb begin
    mask = ram_pkg::data_mask(bus.shape);
    st_nxt = st_r;
    if (bus.we) begin
      for (int i = 0; i < ram_pkg::DATA_W; i++) begin
        if (mask[i]) begin
          st_nxt.mem[12'(bus.wbase + 12'(i))] = bus.wdata[i];
        end
      end
    end
    bus.rdata = 16'(st_r.mem >> bus.rbase) & mask;
  end

  // State register; reset restores the preloaded image
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= PRELOAD;
    end else begin
      st_r <= st_nxt;
    end
  end

  property p_write_lands;
    @(posedge ref_clk) disable iff (reset)
    bus.we |=> (16'(st_r.mem >> $past(bus.wbase)) & ram_pkg::data_mask($past(bus.shape)))
      == ($past(bus.wdata) & ram_pkg::data_mask($past(bus.shape)));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("written word not found in storage");

endmodule

// [design/embedded_ram_block.sv]
// Embedded RAM block: shapes, port modes, clocking, bypassable port registers
`timescale 1ns/100ps
module embedded_ram_block #(
  parameter logic [4095:0] PRELOAD = '0 // Configuration image
) (
  input wire logic ref_clk, // System clock, 100 MHz
  input wire logic reset, // Chip-wide reset, async, active high
  input wire logic local_clr, // Local async clear
  input wire logic global_clr, // Global async clear
  input wire logic [1:0] shape, // Depth by width shape
  input wire logic dual_port, // High: separate read and write ports
  input wire logic split_clk, // High: input regs on write clock, output on read
  input wire logic rom_mode, // High: contents read-only
  input wire logic [5:0] reg_sel, // Per path: 1 registered, 0 bypassed
  input wire logic [1:0] wclk_src, // Write clock source select
  input wire logic [1:0] rclk_src, // Read clock source select
  input wire logic wclk_pin, // Write clock, dedicated pin
  input wire logic wclk_global, // Write clock, global signal
  input wire logic wclk_local, // Write clock, local routing
  input wire logic rclk_pin, // Read clock, dedicated pin
  input wire logic rclk_global, // Read clock, global signal
  input wire logic rclk_local, // Read clock, local routing
  input wire logic ctl_global_sel, // High: enables from global signals
  input wire logic we_global, // Write enable, global
  input wire logic we_local, // Write enable, local
  input wire logic re_global, // Read enable, global
  input wire logic re_local, // Read enable, local
  input wire logic wce_global, // Write clock enable, global
  input wire logic wce_local, // Write clock enable, local
  input wire logic rce_global, // Read clock enable, global
  input wire logic rce_local, // Read clock enable, local
  input wire logic [15:0] din, // Write data
  input wire logic [10:0] waddr, // Write address, also single-port address
  input wire logic [10:0] raddr, // Read address in dual-port mode
  output logic [15:0] dout // Read data, narrow shapes in low bits
);

  typedef struct packed {
    logic [2:0] wsync;
    logic [2:0] rsync;
    logic wlvl;
    logic rlvl;
    logic [15:0] din;
    logic [10:0] waddr;
    logic we;
    logic [10:0] raddr;
    logic re;
    logic wstb;
    logic [15:0] dout;
  } blk_st_t;

  blk_st_t st_r;
  blk_st_t st_nxt;
  ram_core_if core_bus ();

  logic clr_any;
  logic wclk_sel;
  logic rclk_sel;
  logic we_live;
  logic re_live;
  logic wce;
  logic rce;
  logic w_rise;
  logic r_rise;
  logic in_ev_w;
  logic in_ev_r;
  logic out_ev;
  logic [15:0] din_eff;
  logic [10:0] waddr_eff;
  logic [10:0] raddr_live;
  logic [10:0] raddr_eff;
  logic we_eff;
  logic re_eff;

  // Bit position of a word for the current shape
  function automatic logic [11:0] bit_base(input logic [10:0] addr, input logic [1:0] shp);
    logic [11:0] words;
    words = 12'(addr) & (12'h0FF << shp);
    words = words | 12'(addr & 11'(~(11'h7FF << (8 + shp))));
    bit_base = 12'(words << (4 - shp));
  endfunction

  // Any clear source resets every block register at once
  assign clr_any = reset | local_clr | global_clr;

  // Clock sources and enable sources
  always_comb begin
    case (wclk_src)
      ram_pkg::CLK_FROM_PIN: wclk_sel = wclk_pin;
      ram_pkg::CLK_FROM_GLOBAL: wclk_sel = wclk_global;
      default: wclk_sel = wclk_local;
    endcase
    case (rclk_src)
      ram_pkg::CLK_FROM_PIN: rclk_sel = rclk_pin;
      ram_pkg::CLK_FROM_GLOBAL: rclk_sel = rclk_global;
      default: rclk_sel = rclk_local;
    endcase
    we_live = ctl_global_sel ? we_global : we_local;
    re_live = ctl_global_sel ? re_global : re_local;
    wce = ctl_global_sel ? wce_global : wce_local;
    rce = ctl_global_sel ? rce_global : rce_local;
  end

  // Clock rise counted once the last two sync stages agree high
  assign w_rise = st_r.wsync[1] & st_r.wsync[2] & ~st_r.wlvl;
  assign r_rise = st_r.rsync[1] & st_r.rsync[2] & ~st_r.rlvl;

  // Section events per port mode and clocking scheme
  always_comb begin
    in_ev_w = w_rise & wce;
    if (split_clk) begin
      in_ev_r = w_rise & wce;
      out_ev = r_rise & rce;
    end else if (dual_port) begin
      in_ev_r = r_rise & rce;
      out_ev = r_rise & rce;
    end else begin
      in_ev_r = w_rise & rce;
      out_ev = w_rise & rce;
    end
  end

  // Register or bypass for each port path
  always_comb begin
    raddr_live = dual_port ? raddr : waddr;
    din_eff = reg_sel[ram_pkg::SEL_DIN] ? st_r.din : din;
    waddr_eff = reg_sel[ram_pkg::SEL_WADDR] ? st_r.waddr : waddr;
    we_eff = reg_sel[ram_pkg::SEL_WE] ? st_r.we : we_live;
    raddr_eff = reg_sel[ram_pkg::SEL_RADDR] ? st_r.raddr : raddr_live;
    re_eff = reg_sel[ram_pkg::SEL_RE] ? st_r.re : re_live;
  end

  // Storage port drive; write strobe self-timed after the write edge
  always_comb begin
    core_bus.we = st_r.wstb & we_eff & ~rom_mode;
    core_bus.wbase = bit_base(waddr_eff, shape);
    core_bus.wdata = din_eff;
    core_bus.rbase = bit_base(raddr_eff, shape);
    core_bus.shape = shape;
  end

  // Read data out, registered or following the read address
  assign dout = reg_sel[ram_pkg::SEL_DOUT] ? st_r.dout : core_bus.rdata;

  // Next state of all block registers
  always_comb begin
    st_nxt = st_r;
    st_nxt.wsync = {st_r.wsync[1:0], wclk_sel};
    st_nxt.rsync = {st_r.rsync[1:0], rclk_sel};
    st_nxt.wlvl = (st_r.wsync[1] == st_r.wsync[2]) ? st_r.wsync[2] : st_r.wlvl;
    st_nxt.rlvl = (st_r.rsync[1] == st_r.rsync[2]) ? st_r.rsync[2] : st_r.rlvl;
    st_nxt.wstb = in_ev_w;
    if (in_ev_w) begin
      st_nxt.din = din;
      st_nxt.waddr = waddr;
      st_nxt.we = we_live;
    end
    if (in_ev_r) begin
      st_nxt.raddr = raddr_live;
      st_nxt.re = re_live;
    end
    if (out_ev && re_eff) begin
      st_nxt.dout = core_bus.rdata;
    end
  end

  // Block registers, asynchronously cleared
  always_ff @(posedge ref_clk or posedge clr_any) begin
    if (clr_any) begin
      st_r <= '{wsync: ram_pkg::SYNC_RST, rsync: ram_pkg::SYNC_RST, din: ram_pkg::DATA_RST,
                waddr: ram_pkg::ADDR_RST, we: 1'b0, raddr: ram_pkg::ADDR_RST, re: 1'b0,
                wlvl: 1'b0, rlvl: 1'b0, wstb: 1'b0, dout: ram_pkg::DATA_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Storage array
  ram_core #(
    .PRELOAD(PRELOAD)
  ) u_core (
    .ref_clk(ref_clk),
    .reset(reset),
    .bus(core_bus)
  );

  property p_write_hold;
    @(posedge ref_clk) disable iff (clr_any)
    !in_ev_w |=> $stable(st_r.din) && $stable(st_r.waddr) && $stable(st_r.we);
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write registers moved without enable");

  property p_strobe_follows_edge;
    @(posedge ref_clk) disable iff (clr_any)
    st_r.wstb |-> $past(w_rise) && $past(wce);
  endproperty
  a_strobe_follows_edge: assert property (p_strobe_follows_edge) else $error("write strobe without write edge");

  property p_strobe_once;
    @(posedge ref_clk) disable iff (clr_any)
    st_r.wstb |=> !st_r.wstb;
  endproperty
  a_strobe_once: assert property (p_strobe_once) else $error("write strobe longer than one cycle");

  property p_waddr_capture;
    @(posedge ref_clk) disable iff (clr_any)
    in_ev_w |=> st_r.waddr == $past(waddr);
  endproperty
  a_waddr_capture: assert property (p_waddr_capture) else $error("write address not captured");

  property p_bypass_out;
    @(posedge ref_clk) disable iff (clr_any)
    !reg_sel[ram_pkg::SEL_DOUT] |-> dout == core_bus.rdata;
  endproperty
  a_bypass_out: assert property (p_bypass_out) else $error("bypassed output not following array");

  property p_reg_out;
    @(posedge ref_clk) disable iff (clr_any)
    out_ev && re_eff |=> st_r.dout == $past(core_bus.rdata);
  endproperty
  a_reg_out: assert property (p_reg_out) else $error("output register missed read edge");

  property p_read_own_clock;
    @(posedge ref_clk) disable iff (clr_any)
    dual_port && !split_clk && !r_rise |=> $stable(st_r.raddr);
  endproperty
  a_read_own_clock: assert property (p_read_own_clock) else $error("read address moved off read clock");

  property p_split_out;
    @(posedge ref_clk) disable iff (clr_any)
    split_clk && !(r_rise && rce) |=> $stable(st_r.dout);
  endproperty
  a_split_out: assert property (p_split_out) else $error("output register moved off output clock");

  property p_rom_no_write;
    @(posedge ref_clk) disable iff (clr_any)
    rom_mode |-> !core_bus.we;
  endproperty
  a_rom_no_write: assert property (p_rom_no_write) else $error("write reached array in read-only use");

  property p_read_hold;
    @(posedge ref_clk) disable iff (clr_any)
    !in_ev_r |=> $stable(st_r.raddr) && $stable(st_r.re);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read registers moved without enable");

  property p_single_addr;
    @(posedge ref_clk) disable iff (clr_any)
    !dual_port && in_ev_r |=> st_r.raddr == $past(waddr);
  endproperty
  a_single_addr: assert property (p_single_addr) else $error("single-port read address not shared");

  property p_clear_regs;
    @(posedge ref_clk)
    clr_any && $past(clr_any) |-> st_r.dout == ram_pkg::DATA_RST && !st_r.wstb && !st_r.we;
  endproperty
  a_clear_regs: assert property (p_clear_regs) else $error("block register not cleared");

  property p_out_lanes;
    @(posedge ref_clk) disable iff (clr_any)
    out_ev && re_eff |=> (st_r.dout & ~ram_pkg::data_mask($past(shape))) == 16'h0000;
  endproperty
  a_out_lanes: assert property (p_out_lanes) else $error("read data outside low lanes");

  property p_lane_align;
    @(posedge ref_clk) disable iff (clr_any)
    core_bus.we |-> (core_bus.wbase & ((12'h010 >> shape) - 12'h001)) == 12'h000;
  endproperty
  a_lane_align: assert property (p_lane_align) else $error("write base not on a word boundary");

  property p_one_write;
    @(posedge ref_clk) disable iff (clr_any)
    core_bus.we |=> !core_bus.we;
  endproperty
  a_one_write: assert property (p_one_write) else $error("more than one write per write edge");

  property p_re_gate;
    @(posedge ref_clk) disable iff (clr_any)
    out_ev && !re_eff |=> $stable(st_r.dout);
  endproperty
  a_re_gate: assert property (p_re_gate) else $error("output register loaded without read enable");

endmodule

// [dv/user_logic_model.sv]
// User logic model driving the RAM block section clocks, enables and data
`timescale 1ns/100ps
module user_logic_model (
  input wire logic ref_clk, // System clock
  input wire logic dual_port, // Block in dual-port mode
  input wire logic split_clk, // Block in split clock scheme
  input wire logic [1:0] wclk_src, // Write clock source in use
  input wire logic [1:0] rclk_src, // Read clock source in use
  input wire logic ctl_global_sel, // Enables taken from global lines
  output logic wclk_pin, // Write clock, pin
  output logic wclk_global, // Write clock, global
  output logic wclk_local, // Write clock, local
  output logic rclk_pin, // Read clock, pin
  output logic rclk_global, // Read clock, global
  output logic rclk_local, // Read clock, local
  output logic we_global, // Write enable, global
  output logic we_local, // Write enable, local
  output logic re_global, // Read enable, global
  output logic re_local, // Read enable, local
  output logic wce_global, // Write clock enable, global
  output logic wce_local, // Write clock enable, local
  output logic rce_global, // Read clock enable, global
  output logic rce_local, // Read clock enable, local
  output logic [15:0] din, // Write data
  output logic [10:0] waddr, // Write address
  output logic [10:0] raddr // Read address
);
  logic wclk_v = 1'b0, rclk_v = 1'b0, we_v = 1'b0, re_v = 1'b0, wce_v = 1'b0, rce_v = 1'b0;

  initial begin
    din = 16'h0000;
    waddr = 11'h000;
    raddr = 11'h000;
  end

  // Only the selected clock line moves, the others stand still
  assign wclk_pin = wclk_v & (wclk_src == 2'h0);
  assign wclk_global = wclk_v & (wclk_src == 2'h1);
  assign wclk_local = wclk_v & wclk_src[1];
  assign rclk_pin = rclk_v & (rclk_src == 2'h0);
  assign rclk_global = rclk_v & (rclk_src == 2'h1);
  assign rclk_local = rclk_v & rclk_src[1];

  // Unselected enable lines carry the opposite level
  assign we_global = ctl_global_sel ? we_v : ~we_v;
  assign we_local = ctl_global_sel ? ~we_v : we_v;
  assign re_global = ctl_global_sel ? re_v : ~re_v;
  assign re_local = ctl_global_sel ? ~re_v : re_v;
  assign wce_global = ctl_global_sel ? wce_v : ~wce_v;
  assign wce_local = ctl_global_sel ? ~wce_v : wce_v;
  assign rce_global = ctl_global_sel ? rce_v : ~rce_v;
  assign rce_local = ctl_global_sel ? ~rce_v : rce_v;

  // One section clock pulse, long enough for the synchronisers
  task automatic pulse(input logic on_r);
    rclk_v <= on_r;
    wclk_v <= ~on_r;
    repeat (4) @(negedge ref_clk);
    rclk_v <= 1'b0;
    wclk_v <= 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  // Write one word; en is the write clock enable
  task automatic write_word(input logic [10:0] a, input logic [15:0] d, input logic en);
    @(negedge ref_clk);
    waddr <= a;
    din <= d;
    we_v <= 1'b1;
    wce_v <= en;
    pulse(1'b0);
    we_v <= 1'b0;
    wce_v <= 1'b0;
    din <= ~d;
  endtask

  // Read one word, never while a write is in flight
  task automatic read_word(input logic [10:0] a, input logic en);
    @(negedge ref_clk);
    if (dual_port) begin
      raddr <= a;
    end else begin
      waddr <= a;
    end
    re_v <= 1'b1;
    rce_v <= en;
    wce_v <= split_clk;
    pulse(dual_port & ~split_clk);
    pulse(dual_port);
    re_v <= 1'b0;
    rce_v <= 1'b0;
    wce_v <= 1'b0;
  endtask

  // Move the read address only, no clock
  task automatic peek(input logic [10:0] a);
    @(negedge ref_clk);
    raddr <= a;
    @(negedge ref_clk);
  endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the embedded RAM block
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module testbench;
  localparam logic [4095:0] IMAGE = 4096'hA5C3; // Preloaded lookup contents
  logic ref_clk = 1'b0, reset = 1'b1, local_clr = 1'b0, global_clr = 1'b0;
  logic dual_port = 1'b1, split_clk = 1'b0, rom_mode = 1'b0, ctl_global_sel = 1'b0;
  logic [1:0] shape = 2'h0, wclk_src = 2'h0, rclk_src = 2'h0;
  logic [5:0] reg_sel = 6'h3F;
  logic wclk_pin, wclk_global, wclk_local, rclk_pin, rclk_global, rclk_local;
  logic we_global, we_local, re_global, re_local, wce_global, wce_local, rce_global, rce_local;
  logic [15:0] din, dout, msk;
  logic [10:0] waddr, raddr, top;
  int n_fail = 0, num_checks = 0;

  user_logic_model i_user (.ref_clk, .dual_port, .split_clk, .wclk_src, .rclk_src, .ctl_global_sel,
    .wclk_pin, .wclk_global, .wclk_local, .rclk_pin, .rclk_global, .rclk_local, .we_global, .we_local,
    .re_global, .re_local, .wce_global, .wce_local, .rce_global, .rce_local, .din, .waddr, .raddr);

  embedded_ram_block #(.PRELOAD(IMAGE)) i_dut (.ref_clk, .reset, .local_clr, .global_clr, .shape,
    .dual_port, .split_clk, .rom_mode, .reg_sel, .wclk_src, .rclk_src, .wclk_pin, .wclk_global,
    .wclk_local, .rclk_pin, .rclk_global, .rclk_local, .ctl_global_sel, .we_global, .we_local,
    .re_global, .re_local, .wce_global, .wce_local, .rce_global, .rce_local, .din, .waddr, .raddr, .dout);

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Counts and verdict
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    reset <= 1'b0;
    i_user.read_word(11'h000, 1'b1);
    `CHK(dout, 16'hA5C3)
    rom_mode <= 1'b1;
    i_user.write_word(11'h000, 16'h1234, 1'b1);
    i_user.read_word(11'h000, 1'b1);
    `CHK(dout, 16'hA5C3)
    rom_mode <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      shape <= s[1:0];
      wclk_src <= s[1:0];
      rclk_src <= 2'h3 - s[1:0];
      ctl_global_sel <= s[0];
      top = 11'((256 << s) - 1);
      msk = 16'((17'h1 << (16 >> s)) - 17'h1);
      i_user.write_word(top, 16'hB6D9, 1'b1);
      i_user.write_word(11'h000, 16'h4926, 1'b1);
      i_user.read_word(top, 1'b1);
      `CHK(dout, 16'hB6D9 & msk)
      i_user.read_word(11'h7FF, 1'b1);
      `CHK(dout, 16'hB6D9 & msk)
      i_user.read_word(11'h000, 1'b1);
      `CHK(dout, 16'h4926 & msk)
    end
    shape <= 2'h0;
    i_user.write_word(11'h000, 16'h5A5A, 1'b1);
    i_user.write_word(11'h005, 16'h1111, 1'b0);
    i_user.read_word(11'h000, 1'b1);
    `CHK(dout, 16'h5A5A)
    i_user.read_word(11'h005, 1'b0);
    `CHK(dout, 16'h5A5A)
    i_user.read_word(11'h005, 1'b1);
    `CHK(dout, 16'h0000)
    reg_sel <= 6'h00;
    i_user.peek(11'h000);
    `CHK(dout, 16'h5A5A)
    i_user.peek(11'h005);
    `CHK(dout, 16'h0000)
    reg_sel <= 6'h3F;
    dual_port <= 1'b0;
    i_user.write_word(11'h007, 16'hC3C3, 1'b1);
    i_user.read_word(11'h007, 1'b1);
    `CHK(dout, 16'hC3C3)
    dual_port <= 1'b1;
    split_clk <= 1'b1;
    i_user.read_word(11'h000, 1'b1);
    `CHK(dout, 16'h5A5A)
    split_clk <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      i_user.read_word(11'h007, 1'b1);
      `CHK(dout, 16'hC3C3)
      local_clr <= (c == 0);
      global_clr <= (c == 1);
      @(negedge ref_clk);
      `CHK(dout, 16'h0000)
      local_clr <= 1'b0;
      global_clr <= 1'b0;
    end
    reset <= 1'b1;
    @(negedge ref_clk);
    reset <= 1'b0;
    i_user.read_word(11'h000, 1'b1);
    `CHK(dout, 16'hA5C3)
    complete_run();
  end
endmodule
